// *** ata_rd_pkg.sv ***
// Constants, field layouts and carriers for the ATA read command block.
// Assumes an APB slave with 32-bit data and a word-wide media stream.
package ata_rd_pkg;
  // ----------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_ERROR = 8'h04;
  localparam logic [7:0] OFF_SECT_CNT = 8'h08;
  localparam logic [7:0] OFF_SECT_NUM = 8'h0c;
  localparam logic [7:0] OFF_CYL_LOW = 8'h10;
  localparam logic [7:0] OFF_CYL_HIGH = 8'h14;
  localparam logic [7:0] OFF_DEVICE = 8'h18;
  localparam logic [7:0] OFF_CMD_STATUS = 8'h1c;
  localparam logic [7:0] OFF_CONTROL = 8'h20;
  localparam logic [7:0] OFF_MULTIPLE = 8'h24;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h28;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h2c;
  // ----------------------------------------------------------
  // Opcodes and field positions
  // ----------------------------------------------------------
  localparam logic [7:0] OP_READ_MULTI_EXT = 8'h29;
  localparam logic [7:0] OP_READ_NATIVE_MAX = 8'hf8;
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_UNC = 6;
  localparam int ER_IDN = 4;
  localparam int ER_ABT = 2;
  localparam int CTL_HIGH_SEL = 7;
  localparam int DEV_LBA = 6;
  localparam int IRQ_BLOCK = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_ERROR = 2;
  localparam logic [27:0] LBA28_MAX = 28'hfffffff;
  localparam logic [7:0] WORDS_PER_SECTOR_M1 = 8'hff;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] RESET_IRQ = 3'h0;
  // ----------------------------------------------------------
  // Types
  // ----------------------------------------------------------
  typedef struct packed {
    logic [7:0] prev;
    logic [7:0] cur;
  } byte_pair_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_START = 2'b01,
    S_XFER = 2'b10
  } cmd_state_t;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
    logic err;
  } media_in_t;

  typedef struct packed {
    cmd_state_t st;
    logic [7:0] device;
    logic [7:0] control;
    logic [7:0] multiple;
    logic [7:0] error;
    logic err_bit;
    logic [47:0] result;
    logic [3:0] head;
    logic [47:0] lba;
    logic [16:0] remain;
    logic [7:0] blk_cnt;
    logic [7:0] word_cnt;
    logic [15:0] word;
    logic word_full;
    logic start;
    logic [47:0] media_lba;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [31:0] rdata;
  } ctl_state_t;
endpackage

// *** byte_pair_reg.sv ***
// Two-deep byte register: a write pushes the current byte to previous.
// Assumes writes arrive as single-cycle strobes on the same clock.
`timescale 1ns/100ps
module byte_pair_reg (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [7:0] wr_byte,
  output ata_rd_pkg::byte_pair_t pair
);
  import ata_rd_pkg::*;

  byte_pair_t q, d;

  always_comb begin
    d = q;
    if (wr_en) begin
      d.prev = q.cur;
      d.cur = wr_byte;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pair = q;
endmodule

// *** ata_multiread_and_native_max.sv ***
// Command interpreter for the extended multi-sector read and the
// native max address query, with an APB register face.
// Assumes the media engine streams 16-bit words on this clock.
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module ata_multiread_and_native_max (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [47:0] native_max_lba,
  input wire logic [15:0] max_cylinder,
  input wire logic [3:0] max_head,
  input wire logic [7:0] max_sector,
  output logic media_start,
  output logic [47:0] media_lba,
  input ata_rd_pkg::media_in_t media_in,
  output logic media_ready,
  output logic irq
);
  import ata_rd_pkg::*;

  // ----------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= OFF_IRQ_MASK);
  endfunction

  function automatic logic [7:0] hsel_byte(input logic [47:0] v,
                                            input int idx,
                                            input logic hsel);
    logic [7:0] lo;
    logic [7:0] hi;
    lo = v[idx*8 +: 8];
    hi = v[idx*8 + 24 +: 8];
    hsel_byte = hsel ? hi : lo;
  endfunction

  ctl_state_t q, d;
  byte_pair_t pairs [4];
  logic [3:0] pair_wr;
  logic wr_acc, rd_acc, setup;
  logic [15:0] count16;
  logic [47:0] start_lba;
  logic [47:0] clamped;
  logic sector_end, last_sector, block_end;
  logic [2:0] irq_set;
  logic [7:0] status;
  logic hsel;

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign hsel = q.control[CTL_HIGH_SEL];

  // ----------------------------------------------------------
  // Shadow register pairs: count, sector, cyl low, cyl high
  // ----------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pair
      // Previous byte only holds the upper part if written first
      assign pair_wr[gi] = wr_acc &&
        (paddr == OFF_SECT_CNT + 8'(gi * 4));
      byte_pair_reg u_pair (
        .clock(clock),
        .reset_n(reset_n),
        .wr_en(pair_wr[gi]),
        .wr_byte(pwdata[7:0]),
        .pair(pairs[gi])
      );
    end
  endgenerate

  assign count16 = {pairs[0].prev, pairs[0].cur};
  assign start_lba = {pairs[3].prev, pairs[2].prev, pairs[1].prev,
                      pairs[3].cur, pairs[2].cur, pairs[1].cur};
  // Anything past 28 bits reads as the largest 28-bit address
  assign clamped = (native_max_lba > {20'h00000, LBA28_MAX}) ?
    {20'h00000, LBA28_MAX} : native_max_lba;

  // ----------------------------------------------------------
  // Transfer bookkeeping
  // ----------------------------------------------------------
  assign media_ready = (q.st == S_XFER) && !q.word_full;
  assign sector_end = media_ready && media_in.valid &&
    (q.word_cnt == WORDS_PER_SECTOR_M1);
  assign last_sector = (q.remain == 17'h00001);
  // A short final block still ends with its own interrupt
  assign block_end = sector_end &&
    ((q.blk_cnt == q.multiple - 8'h01) || last_sector);

  assign status = {(q.st != S_IDLE) && !q.word_full, 1'b1, 1'b0, 1'b1,
                   q.word_full, 2'b00, q.err_bit};

  always_comb begin
    logic [7:0] cmd;
    logic [2:0] clr;
    d = q;
    cmd = pwdata[7:0];
    clr = 3'h0;
    irq_set = 3'h0;
    d.start = 1'b0;

    // --------------------------------------------------------
    // Register writes
    // --------------------------------------------------------
    if (wr_acc) begin
      case (paddr)
        OFF_DEVICE: begin
          d.device = pwdata[7:0];
        end
        OFF_CONTROL: begin
          d.control = pwdata[7:0];
        end
        OFF_MULTIPLE: begin
          d.multiple = pwdata[7:0];
        end
        OFF_IRQ_STATUS: begin
          clr = pwdata[2:0];
        end
        OFF_IRQ_MASK: begin
          d.irq_mask = pwdata[2:0];
        end
        default: begin
        end
      endcase
    end

    // --------------------------------------------------------
    // Command issue, only taken while idle
    // --------------------------------------------------------
    if (wr_acc && paddr == OFF_CMD_STATUS && q.st == S_IDLE) begin
      d.error = 8'h00;
      d.err_bit = 1'b0;
      if (cmd == OP_READ_MULTI_EXT && q.multiple != 8'h00) begin
        d.st = S_START;
        d.lba = start_lba;
        d.remain = {count16 == 16'h0000, count16};
        d.blk_cnt = 8'h00;
        d.result = start_lba;
      end else if (cmd == OP_READ_NATIVE_MAX) begin
        // The reduced maximum is never consulted here
        if (q.device[DEV_LBA]) begin
          d.result = clamped;
          d.head = clamped[27:24];
        end else begin
          d.result = {24'h000000, max_cylinder, max_sector};
          d.head = max_head;
        end
        irq_set[IRQ_DONE] = 1'b1;
      end else begin
        // Block size unset or opcode unknown: abort
        d.error[ER_ABT] = 1'b1;
        d.err_bit = 1'b1;
        irq_set[IRQ_ERROR] = 1'b1;
      end
    end

    // --------------------------------------------------------
    // Sector sequencing
    // --------------------------------------------------------
    case (q.st)
      S_IDLE: begin
      end
      S_START: begin
        d.start = 1'b1;
        d.media_lba = q.lba;
        d.word_cnt = 8'h00;
        d.st = S_XFER;
      end
      S_XFER: begin
        if (media_in.err) begin
          // Stop here; the failing address stays readable
          d.result = q.lba;
          d.error[ER_UNC] = 1'b1;
          d.err_bit = 1'b1;
          irq_set[IRQ_ERROR] = 1'b1;
          d.st = S_IDLE;
        end else if (media_ready && media_in.valid) begin
          d.word = media_in.word;
          d.word_full = 1'b1;
          d.word_cnt = q.word_cnt + 8'h01;
          if (sector_end) begin
            d.lba = q.lba + 48'h1;
            d.result = q.lba;
            d.remain = q.remain - 17'h00001;
            d.blk_cnt = block_end ? 8'h00 : q.blk_cnt + 8'h01;
            irq_set[IRQ_BLOCK] = block_end;
            irq_set[IRQ_DONE] = last_sector;
            d.st = last_sector ? S_IDLE : S_START;
          end
        end
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase

    // Host read of the data port frees the word holder
    if (rd_acc && paddr == OFF_DATA) begin
      d.word_full = 1'b0;
    end

    // --------------------------------------------------------
    // Read data, captured in the setup phase
    // --------------------------------------------------------
    if (setup) begin
      case (paddr)
        OFF_DATA: d.rdata = {16'h0000, q.word};
        OFF_ERROR: d.rdata = {24'h000000, q.error};
        OFF_SECT_CNT: begin
          d.rdata = {24'h000000, hsel ? q.remain[15:8] : q.remain[7:0]};
        end
        OFF_SECT_NUM: d.rdata = {24'h000000, hsel_byte(q.result, 0, hsel)};
        OFF_CYL_LOW: d.rdata = {24'h000000, hsel_byte(q.result, 1, hsel)};
        OFF_CYL_HIGH: d.rdata = {24'h000000, hsel_byte(q.result, 2, hsel)};
        OFF_DEVICE: d.rdata = {24'h000000, q.device[7:4], q.head};
        OFF_CMD_STATUS: d.rdata = {24'h000000, status};
        OFF_CONTROL: d.rdata = {24'h000000, q.control};
        OFF_MULTIPLE: d.rdata = {24'h000000, q.multiple};
        OFF_IRQ_STATUS: d.rdata = {29'h00000000, q.irq_status};
        OFF_IRQ_MASK: d.rdata = {29'h00000000, q.irq_mask};
        default: d.rdata = 32'h00000000;
      endcase
    end

    // A new event beats a clear in the same cycle
    d.irq_status = (q.irq_status & ~clr) | irq_set;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.st <= S_IDLE;
      q.control <= RESET_BYTE;
      q.irq_mask <= RESET_IRQ;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  assign prdata = q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign media_start = q.start;
  assign media_lba = q.media_lba;
  assign irq = |(q.irq_status & q.irq_mask);
endmodule

// *** ata_media_model.sv ***
// Media engine model: streams 256 words per sector.
// Assumes media_start and media_lba come from the block, same clock.
`timescale 1ns/100ps
module ata_media_model
  import ata_rd_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic media_start,
  input wire logic [47:0] media_lba,
  input wire logic media_ready,
  input wire logic [47:0] err_lba,
  output ata_rd_pkg::media_in_t media_in,
  output int n_start
);
  // ----
  // Sector stream
  // ----
  logic [8:0] left_q;
  // A gap after each word keeps the slow path exercised
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      media_in <= '0;
      left_q <= 9'h0;
      n_start <= 0;
    end else if (media_start) begin
      n_start <= n_start + 1;
      media_in.err <= media_lba == err_lba;
      left_q <= (media_lba == err_lba) ? 9'h0 : 9'h100;
    end else begin
      media_in.err <= 1'b0;
      if (media_in.valid && media_ready) begin
        left_q <= left_q - 9'h1;
        media_in.valid <= 1'b0;
        media_in.word <= ~media_in.word;
      end else if (left_q != 9'h0 && !media_in.valid) begin
        media_in.valid <= 1'b1;
        media_in.word <= {media_lba[7:0], 8'(9'h100 - left_q)};
      end
    end
  end
endmodule

// *** ata_rd_properties.sv ***
// Port checker for the read command block.
// Assumes one clock and the block's own port names.
`timescale 1ns/100ps
module ata_rd_props
  import ata_rd_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [47:0] native_max_lba,
  input wire logic [15:0] max_cylinder,
  input wire logic [3:0] max_head,
  input wire logic [7:0] max_sector,
  input wire logic media_start,
  input wire logic [47:0] media_lba,
  input ata_rd_pkg::media_in_t media_in,
  input wire logic media_ready,
  input wire logic irq
);
  // ----
  // Port relations
  // ----
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire acc = psel && penable;
  wire cmd29 = acc && pwrite && paddr == OFF_CMD_STATUS
    && pwdata[7:0] == OP_READ_MULTI_EXT;
  wire took = media_in.valid && media_ready;
  AST_ZERO_WAIT: assert property (acc |-> pready)
    else $error("no ready in access");
  AST_UNMAPPED: assert property (acc && paddr > OFF_IRQ_MASK |-> pslverr)
    else $error("unmapped not refused");
  AST_MAPPED: assert property (acc && paddr <= OFF_IRQ_MASK
    && paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped refused");
  AST_UNMAP_RD: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  AST_START_PULSE: assert property (media_start |=> !media_start)
    else $error("start too long");
  AST_LBA_HOLD: assert property (media_start
    |=> $stable(media_lba)[*8]) else $error("address moved");
  AST_START_CAUSE: assert property (media_start |-> $past(cmd29)
    || $past(cmd29, 2) || $past(took) || $past(took, 2))
    else $error("start without cause");
  AST_MASK_OFF: assert property (acc && pwrite
    && paddr == OFF_IRQ_MASK && pwdata[2:0] == 3'h0 |=> !irq)
    else $error("masked irq high");
  cover property (cmd29);
  cover property (media_in.err);
  cover property (irq && acc);
endmodule

bind ata_multiread_and_native_max ata_rd_props u_props (.*);

// *** tb_ata_multiread_and_native_max.sv ***
// Bench for the read command block: APB host plus media model.
// Assumes the block answers APB with no wait states or later.
`timescale 1ns/100ps
module tb_ata_multiread_and_native_max;
  import ata_rd_pkg::*;
  logic clock = 1'b0, reset_n = 1'b0, se;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, media_start, media_ready, irq;
  logic [7:0] paddr = 8'h0, max_sector = 8'h3f;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic [47:0] native_max_lba = 48'h12_3456_789a;
  logic [47:0] media_lba, err_lba = 48'h1122_3344_55ff;
  logic [15:0] max_cylinder = 16'h3fff;
  logic [3:0] max_head = 4'hf;
  media_in_t media_in;
  int n_start, n_mismatch = 0, num_checks = 0, cyc = 0;
  ata_multiread_and_native_max u_dut (.*);
  ata_media_model u_media (.*);
  always #5 clock = ~clock;
  // ----
  // Host tasks
  // ----
  task automatic complete_run();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Ceiling well above the roughly 5k cycles the tests need
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd_q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hff);
    apb(1'b0, a, 8'h0);
    chk(rd_q & m, e);
  endtask
  task automatic poll(input logic [7:0] m);
    rd_q = 32'h0;
    while ((rd_q[7:0] & m) == 8'h0) apb(1'b0, OFF_CMD_STATUS, 8'h0);
  endtask
  task automatic load(input logic [47:0] l, input logic [15:0] n);
    apb(1'b1, OFF_SECT_CNT, n[15:8]);
    apb(1'b1, OFF_SECT_CNT, n[7:0]);
    apb(1'b1, OFF_SECT_NUM, l[31:24]);
    apb(1'b1, OFF_SECT_NUM, l[7:0]);
    apb(1'b1, OFF_CYL_LOW, l[39:32]);
    apb(1'b1, OFF_CYL_LOW, l[15:8]);
    apb(1'b1, OFF_CYL_HIGH, l[47:40]);
    apb(1'b1, OFF_CYL_HIGH, l[23:16]);
    apb(1'b1, OFF_DEVICE, 8'h40);
    apb(1'b1, OFF_CMD_STATUS, OP_READ_MULTI_EXT);
  endtask
  task automatic sect(input logic [47:0] l);
    for (int w = 0; w < 256; w++) begin
      poll(8'h08);
      if (w == 0) chk(media_lba, l);
      apb(1'b0, OFF_DATA, 8'h0);
      chk(rd_q[15:0], {l[7:0], 8'(w)});
    end
  endtask
  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    apb(1'b1, OFF_DEVICE, 8'h40);
    apb(1'b1, OFF_CMD_STATUS, OP_READ_NATIVE_MAX);
    rc(OFF_SECT_NUM, 32'hff);
    rc(OFF_CYL_LOW, 32'hff);
    rc(OFF_CYL_HIGH, 32'hff);
    apb(1'b1, OFF_CONTROL, 8'h80);
    rc(OFF_SECT_NUM, 32'h0f);
    rc(OFF_CYL_LOW, 32'h00);
    apb(1'b1, OFF_CONTROL, 8'h00);
    apb(1'b1, OFF_DEVICE, 8'h00);
    apb(1'b1, OFF_CMD_STATUS, OP_READ_NATIVE_MAX);
    rc(OFF_SECT_NUM, 32'h3f);
    rc(OFF_CYL_LOW, 32'hff);
    rc(OFF_CYL_HIGH, 32'h3f);
    rc(OFF_CMD_STATUS, 32'h40, 32'h41);
    // Block size still unset, so the read is refused
    load(48'h0, 16'h1);
    rc(OFF_ERROR, 32'h04, 32'h04);
    chk(n_start, 0);
    apb(1'b1, OFF_IRQ_STATUS, 8'h07);
    apb(1'b1, OFF_MULTIPLE, 8'h01);
    apb(1'b1, OFF_IRQ_MASK, 8'h01);
    load(48'ha1b2_c3d4_e5f6, 16'h2);
    sect(48'ha1b2_c3d4_e5f6);
    chk(irq, 1'b1);
    apb(1'b1, OFF_IRQ_STATUS, 8'h01);
    chk(irq, 1'b0);
    sect(48'ha1b2_c3d4_e5f7);
    apb(1'b1, OFF_IRQ_MASK, 8'h00);
    chk(irq, 1'b0);
    rc(OFF_IRQ_STATUS, 32'h03, 32'h07);
    rc(OFF_CMD_STATUS, 32'h40, 32'h49);
    chk(n_start, 2);
    apb(1'b1, OFF_IRQ_STATUS, 8'h07);
    // Second sector fails, so no third fetch may start
    load(48'h1122_3344_55fe, 16'h3);
    sect(48'h1122_3344_55fe);
    poll(8'h01);
    rc(OFF_ERROR, 32'h40, 32'h40);
    chk(n_start, 4);
    rc(OFF_SECT_NUM, 32'hff);
    rc(OFF_CYL_HIGH, 32'h44);
    apb(1'b1, OFF_CONTROL, 8'h80);
    rc(OFF_SECT_NUM, 32'h33);
    rc(OFF_CYL_HIGH, 32'h11);
    apb(1'b0, 8'h30, 8'h0);
    chk({se, rd_q}, 33'h1_0000_0000);
    // Zero count is the longest transfer, so a fetch must start
    load(48'h0, 16'h0);
    poll(8'h08);
    chk(n_start, 5);
    complete_run();
  end
endmodule
